// *** src/psl_regs.svh ***
// offsets, field positions, reset values and timing figures of the status lamp driver
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

// ==========================================
// register offsets (byte addresses)
`define PSL_OFF_MODE 8'h00
`define PSL_OFF_BEHAV 8'h04
`define PSL_OFF_POLAR 8'h08
`define PSL_OFF_STATUS 8'h0c

// ==========================================
// behaviour register fields
`define PSL_BH_COMB_LSB 0
`define PSL_BH_STR_LSB 4
`define PSL_BH_RATE_LSB 8
`define PSL_BH_ACTSEL 16
`define PSL_BH_PULSE 17
`define PSL_BH_W 18

// ==========================================
// reset values
`define PSL_RST_MODE 16'h3210
`define PSL_RST_BEHAV 18'h0_0000
`define PSL_RST_POLAR 4'h0

// ==========================================
// mode codes
`define PSL_MODE_LINK_ANY 4'h0
`define PSL_MODE_LINK_1000 4'h1
`define PSL_MODE_LINK_100 4'h2
`define PSL_MODE_LINK_10 4'h3
`define PSL_MODE_LINK_100_1000 4'h4
`define PSL_MODE_LINK_10_1000 4'h5
`define PSL_MODE_LINK_10_100 4'h6
`define PSL_MODE_DUPLEX 4'h8
`define PSL_MODE_COLL 4'h9
`define PSL_MODE_ACT 4'ha
`define PSL_MODE_ANFAULT 4'hc
`define PSL_MODE_OFF 4'he
`define PSL_MODE_ON 4'hf

// ==========================================
// link speed codes
`define PSL_SPD_10 2'h0
`define PSL_SPD_100 2'h1
`define PSL_SPD_1000 2'h2

// ==========================================
// timing
`define PSL_CLK_NS 8
`define PSL_MS_NS 1000000
`define PSL_PULSE_PERIOD_NS 200000
`define PSL_PULSE_DUTY_PCT 20
`define PSL_BLINK_HALF0_MS 200
`define PSL_STRETCH0_MS 50

`endif

// *** src/psl_pkg.sv ***
// types shared by the status lamp driver files
package psl_pkg;
  typedef logic [3:0] psl_mode_t;
  typedef logic [1:0] psl_rate_t;
  typedef logic [1:0] psl_speed_t;
  typedef logic [8:0] psl_ms_t;
  typedef enum logic [1:0] {PSL_IDLE, PSL_ON, PSL_OFF} psl_st_e;
endpackage

// *** src/psl_stretch.sv ***
// pulse stretcher for one lamp: on for at least len, then off for at least len
`timescale 1ns/10ps
`include "psl_regs.svh"
module psl_stretch (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire logic event_in,
  input wire psl_pkg::psl_rate_t rate,
  output logic stretch_out
);
  import psl_pkg::*;

  // ==========================================
  // state
  psl_st_e state; // stretch phase
  psl_st_e next_state; // phase to come
  psl_ms_t cnt; // whole ms ticks in this phase
  logic pend; // event seen while busy
  psl_ms_t len_ms; // selected length
  logic phase_done; // phase has run its length

  // length doubles per rate step, shortest first
  assign len_ms = psl_ms_t'(`PSL_STRETCH0_MS) << rate;
  // first tick may be partial, so count one extra
  assign phase_done = ms_tick && (cnt == len_ms);

  // next phase decode
  always_comb begin
    next_state = state;
    unique case (state)
      PSL_IDLE: if (event_in) next_state = PSL_ON;
      PSL_ON: if (phase_done) next_state = PSL_OFF;
      PSL_OFF: if (phase_done) next_state = (pend || event_in) ? PSL_ON : PSL_IDLE;
      // spare code of the 2-bit phase falls back to idle
      default: next_state = PSL_IDLE;
    endcase
  end

  // phase register and tick counter
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= PSL_IDLE;
      cnt <= '0;
      stretch_out <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? '0 : (ms_tick ? cnt + 9'h001 : cnt);
      stretch_out <= (next_state == PSL_ON);
    end
  end

  // remember events that arrive mid-cycle; a new event beats the clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pend <= 1'b0;
    end else begin
      pend <= (state != PSL_IDLE && event_in) || (pend && next_state != PSL_ON);
    end
  end

  // on phase lasts the full selected length
  a_stretch_on_len: assert property (@(posedge core_clk) disable iff (!rst_b)
    (state == PSL_ON && next_state == PSL_OFF) |-> cnt == len_ms)
    else $error("stretch on phase ended early");
endmodule // psl_stretch

// *** src/psl_lamp_drv.sv ***
// status lamp driver: four lamp pins with per-pin mode, combine, blink or stretch
`timescale 1ns/10ps
`include "psl_regs.svh"
// How it works
// - four pins, each with own mode
// - active low after reset, polarity invert
// - mode 0: any link, blink on activity
// - modes 1-3: link at one speed
// - modes 4-6: link at two speeds
// - mode 8: full duplex, collisions blink
// - mode 9: collisions blink, else off
// - mode 10: activity, optional transmit only
// - mode 12: on during negotiation fault
// - mode 14 forced off, 15 on
// - combine disable hides secondary indication in modes 0-6 and 8
// - combine enabled: link plus activity blink, in mode 8 full duplex plus collision blink
// - per-pin blink or stretch, 50% blink
// - stretch holds on and off minimum
// - rate picks 2.5 to 20 Hz
// - rate picks 50 to 400 ms
// - pulsing modulates asserted lamps 5 kHz 20%
// - settings loadable from EEPROM/OTP data
module psl_lamp_drv #(
  parameter int PINS = 4,
  parameter int MS_CYC = `PSL_MS_NS / `PSL_CLK_NS,
  parameter int PULSE_CYC = `PSL_PULSE_PERIOD_NS / `PSL_CLK_NS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic cfg_load,
  input wire logic [15:0] cfg_mode,
  input wire logic [17:0] cfg_behav,
  input wire logic [3:0] cfg_invert,
  input wire logic link_up,
  input wire psl_pkg::psl_speed_t link_speed,
  input wire logic full_duplex,
  input wire logic tx_act,
  input wire logic rx_act,
  input wire logic collision,
  input wire logic an_fault,
  output logic [3:0] status_lamp_pins
);
  import psl_pkg::*;

  // pulse on time, derived from the 20% duty
  localparam int PULSE_ON_CYC = (PULSE_CYC * `PSL_PULSE_DUTY_PCT) / 100;
  // one full blink cycle of the slowest rate
  localparam int BLINK_CYCLE_MS = 2 * `PSL_BLINK_HALF0_MS;

  // ==========================================
  // helper functions

  // link present at the speeds that a link mode asks for
  function automatic logic link_match(input psl_mode_t m, input psl_speed_t s);
    logic g;
    logic f;
    logic t;
    g = (s == `PSL_SPD_1000);
    f = (s == `PSL_SPD_100);
    t = (s == `PSL_SPD_10);
    unique case (m)
      `PSL_MODE_LINK_ANY: link_match = 1'b1;
      `PSL_MODE_LINK_1000: link_match = g;
      `PSL_MODE_LINK_100: link_match = f;
      `PSL_MODE_LINK_10: link_match = t;
      `PSL_MODE_LINK_100_1000: link_match = f | g;
      `PSL_MODE_LINK_10_1000: link_match = t | g;
      `PSL_MODE_LINK_10_100: link_match = t | f;
      default: link_match = 1'b0;
    endcase
  endfunction

  // blink level of a rate: halves of 200/100/50/25 ms, 50% duty
  function automatic logic blink_level(input psl_ms_t ms, input psl_rate_t r);
    psl_ms_t half;
    half = psl_ms_t'(`PSL_BLINK_HALF0_MS) >> r;
    unique case (r)
      2'h0: blink_level = ms >= half;
      2'h1: blink_level = (ms % 9'h0c8) >= half;
      2'h2: blink_level = (ms % 9'h064) >= half;
      2'h3: blink_level = (ms % 9'h032) >= half;
    endcase
  endfunction

  // lamp state of one pin from mode, primary and secondary
  function automatic logic lamp_of(input psl_mode_t m, input logic prim, input logic sec,
                                   input logic comb);
    logic shown;
    shown = comb & sec;
    unique case (m)
      `PSL_MODE_LINK_ANY, `PSL_MODE_LINK_1000, `PSL_MODE_LINK_100, `PSL_MODE_LINK_10,
      `PSL_MODE_LINK_100_1000, `PSL_MODE_LINK_10_1000,
      `PSL_MODE_LINK_10_100: lamp_of = prim & ~shown;
      `PSL_MODE_DUPLEX: lamp_of = prim | shown;
      `PSL_MODE_COLL, `PSL_MODE_ACT: lamp_of = sec;
      `PSL_MODE_ANFAULT: lamp_of = prim;
      `PSL_MODE_ON: lamp_of = 1'b1;
      default: lamp_of = 1'b0;
    endcase
  endfunction

  // ==========================================
  // registers
  logic [15:0] mode_reg; // four 4-bit mode fields
  logic [`PSL_BH_W-1:0] behav_reg; // combine, stretch, rate, select, pulsing
  logic [3:0] polar_reg; // per-pin polarity invert
  logic [3:0] lamp_q; // registered lamp states
  logic [16:0] ms_div; // divider to 1 ms ticks
  logic ms_tick; // one-cycle ms enable
  psl_ms_t ms_cnt; // position in the slowest blink cycle
  logic [14:0] pulse_cnt; // pulsing period counter
  logic pulse_phase; // high in the on part of pulsing

  // field views
  wire logic [3:0] comb_dis = behav_reg[`PSL_BH_COMB_LSB +: 4]; // combine disables
  wire logic [3:0] str_en = behav_reg[`PSL_BH_STR_LSB +: 4]; // stretch enables
  wire logic tx_only = behav_reg[`PSL_BH_ACTSEL]; // activity from transmit only
  wire logic pulse_en = behav_reg[`PSL_BH_PULSE]; // pulsing enable

  // ==========================================
  // bus decode
  wire logic hit_mode = reg_addr == `PSL_OFF_MODE;
  wire logic hit_behav = reg_addr == `PSL_OFF_BEHAV;
  wire logic hit_polar = reg_addr == `PSL_OFF_POLAR;
  wire logic hit_status = reg_addr == `PSL_OFF_STATUS;
  wire logic [31:0] status_word = {19'h0_0000, an_fault, full_duplex, link_speed, link_up,
                                   status_lamp_pins, lamp_q};
  wire logic [31:0] rd_mux = hit_mode ? {16'h0000, mode_reg} :
                             hit_behav ? {14'h0000, behav_reg} :
                             hit_polar ? {28'h000_0000, polar_reg} :
                             hit_status ? status_word : 32'h0000_0000;

  // writes from software; a load from configuration data yields to them
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode_reg <= `PSL_RST_MODE;
      behav_reg <= `PSL_RST_BEHAV;
      polar_reg <= `PSL_RST_POLAR;
    end else if (reg_wr) begin
      if (hit_mode) mode_reg <= reg_wdata[15:0];
      if (hit_behav) behav_reg <= reg_wdata[`PSL_BH_W-1:0];
      if (hit_polar) polar_reg <= reg_wdata[3:0];
    end else if (cfg_load) begin
      mode_reg <= cfg_mode;
      behav_reg <= cfg_behav;
      polar_reg <= cfg_invert;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ==========================================
  // time base: ms ticks and pulsing phase
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ms_div <= '0;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= ms_div == 17'(MS_CYC - 1);
      ms_div <= (ms_div == 17'(MS_CYC - 1)) ? '0 : ms_div + 17'h0_0001;
    end
  end

  // ms position within the slowest blink period
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ms_cnt <= '0;
    end else if (ms_tick) begin
      ms_cnt <= (ms_cnt == psl_ms_t'(BLINK_CYCLE_MS - 1)) ? '0 : ms_cnt + 9'h001;
    end
  end

  // 5 kHz pulsing with 20% on
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pulse_cnt <= '0;
    end else begin
      pulse_cnt <= (pulse_cnt == 15'(PULSE_CYC - 1)) ? '0 : pulse_cnt + 15'h0001;
    end
  end
  assign pulse_phase = pulse_cnt < 15'(PULSE_ON_CYC);

  // ==========================================
  // per-pin indication
  wire logic act_any = tx_only ? tx_act : (tx_act | rx_act);
  wire logic half_coll = link_up & ~full_duplex & collision;

  logic [3:0] next_lamp; // lamp state per pin
  logic [3:0] next_pins; // pin level per pin

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    wire psl_mode_t m = mode_reg[4*i +: 4]; // this pin's mode
    wire psl_rate_t r = behav_reg[`PSL_BH_RATE_LSB + 2*i +: 2]; // this pin's rate
    // event source for the secondary indication
    wire logic evt = (m == `PSL_MODE_DUPLEX) ? half_coll :
                     (m == `PSL_MODE_COLL) ? collision :
                     (m == `PSL_MODE_ACT) ? act_any :
                     (link_up & (tx_act | rx_act));
    // primary condition
    wire logic prim = (m == `PSL_MODE_DUPLEX) ? (link_up & full_duplex) :
                      (m == `PSL_MODE_ANFAULT) ? an_fault :
                      (link_up & link_match(m, link_speed));
    logic str_out; // stretched event
    // blink or stretch per pin
    wire logic sec = str_en[i] ? str_out : (evt & blink_level(ms_cnt, r));

    psl_stretch u_str (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .ms_tick(ms_tick),
      .event_in(evt),
      .rate(r),
      .stretch_out(str_out)
    );

    assign next_lamp[i] = lamp_of(m, prim, sec, ~comb_dis[i]);
    // asserted pin level is low unless inverted; pulsing chops it
    assign next_pins[i] = ~(next_lamp[i] & (~pulse_en | pulse_phase)) ^ polar_reg[i];

    a_force_off_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == `PSL_MODE_OFF) |=> status_lamp_pins[i] == ~$past(polar_reg[i]))
      else $error("forced-off pin asserted");
    a_force_on_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == `PSL_MODE_ON && !pulse_en) |=> status_lamp_pins[i] == $past(polar_reg[i]))
      else $error("forced-on pin not asserted");
    a_reserved_mode_off: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == 4'h7 || m == 4'hb || m == 4'hd) |=> status_lamp_pins[i] == ~$past(polar_reg[i]))
      else $error("reserved mode drives pin");
    a_any_link_gone: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == `PSL_MODE_LINK_ANY && !link_up) |=> status_lamp_pins[i] == ~$past(polar_reg[i]))
      else $error("link lamp on without link");
    a_gig_wrong_speed: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == `PSL_MODE_LINK_1000 && link_speed != `PSL_SPD_1000)
      |=> status_lamp_pins[i] == ~$past(polar_reg[i]))
      else $error("gigabit lamp on at other speed");
    a_combine_off_link: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == `PSL_MODE_LINK_ANY && link_up && comb_dis[i] && !pulse_en)
      |=> status_lamp_pins[i] == $past(polar_reg[i]))
      else $error("combine disabled link lamp not steady");
    a_fault_lamp_on: assert property (@(posedge core_clk) disable iff (!rst_b)
      (m == `PSL_MODE_ANFAULT && an_fault && !pulse_en)
      |=> status_lamp_pins[i] == $past(polar_reg[i]))
      else $error("fault lamp not asserted");
    a_pulse_off_gap: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pulse_en && !pulse_phase) |=> status_lamp_pins[i] == ~$past(polar_reg[i]))
      else $error("pulsed lamp on in off part");
  end

  // ==========================================
  // output flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lamp_q <= 4'h0;
      status_lamp_pins <= 4'hf;
    end else begin
      lamp_q <= next_lamp;
      status_lamp_pins <= next_pins;
    end
  end

  // pulsing period is five thousand per second
  a_pulse_wrap: assert property (@(posedge core_clk) disable iff (!rst_b)
    (pulse_cnt == 15'(PULSE_CYC - 1)) |=> pulse_cnt == 15'h0000 && pulse_phase)
    else $error("pulsing period wrong");
endmodule // psl_lamp_drv

// *** sim/psl_lamp_model.sv ***
// model of the four indicator lamps hanging on the status pins
`timescale 1ns/10ps
module psl_lamp_model (
  input wire logic core_clk,
  input wire logic [3:0] pins,
  input wire logic [3:0] invert,
  input wire logic clr,
  output logic [3:0] lamp_on,
  output int on_cnt
);
  // ==========
  // a lamp is lit while its pin sits at the asserted level
  assign lamp_on = ~(pins ^ invert);
  // lit cycles of lamp 0 since the last clear
  always_ff @(posedge core_clk) begin
    if (clr) begin
      on_cnt <= 0;
    end else begin
      on_cnt <= on_cnt + int'(lamp_on[0]);
    end
  end
endmodule // psl_lamp_model

// *** sim/tb_phy_status_lamp_driver.sv ***
// self-checking bench for the status lamp driver
`timescale 1ns/10ps
module tb_phy_status_lamp_driver;
  import psl_pkg::*;
  localparam int MS = 10; // cycles in a shortened millisecond
  logic core_clk = 0;
  logic rst_b = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [31:0] reg_rdata;
  logic cfg_load = 0;
  logic [15:0] cfg_mode = 0;
  logic [17:0] cfg_behav = 0;
  logic [3:0] cfg_invert = 0;
  logic link_up = 0;
  psl_speed_t link_speed = 0;
  logic full_duplex = 0;
  logic tx_act = 0;
  logic rx_act = 0;
  logic collision = 0;
  logic an_fault = 0;
  logic [3:0] status_lamp_pins;
  logic [3:0] pol = 0; // polarity the bench has programmed
  logic clr = 0;
  logic [3:0] lamp_on;
  int on_cnt;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] d;
  int n;

  always #4 core_clk = ~core_clk;

  psl_lamp_drv #(.MS_CYC(MS), .PULSE_CYC(10)) DUT (
    .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cfg_load,
    .cfg_mode, .cfg_behav, .cfg_invert, .link_up, .link_speed, .full_duplex, .tx_act,
    .rx_act, .collision, .an_fault, .status_lamp_pins
  );
  psl_lamp_model LAMPS (.core_clk, .pins(status_lamp_pins), .invert(pol), .clr, .lamp_on,
    .on_cnt);

  // ==========
  // compare helpers and bus cycles
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_rng(string nm, int lo, int hi, int got);
    tests_run++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic setin(logic lk, logic [1:0] sp, logic fd, logic tx, logic rx, logic co,
                       logic af);
    @(posedge core_clk);
    link_up <= lk;
    link_speed <= sp;
    full_duplex <= fd;
    tx_act <= tx;
    rx_act <= rx;
    collision <= co;
    an_fault <= af;
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask
  // lit cycles of lamp 0 over a window of c cycles
  task automatic lit(int c, output int got);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    repeat (c) @(posedge core_clk);
    #1 got = on_cnt;
  endtask
  task automatic pulse_coll();
    @(posedge core_clk);
    collision <= 1'b1;
    @(posedge core_clk);
    collision <= 1'b0;
  endtask
  // expected steady lamp state with no events
  function automatic logic exp_on(logic [3:0] m, logic lk, logic [1:0] sp, logic fd,
                                  logic af);
    case (m)
      4'h0: return lk;
      4'h1: return lk && sp == 2'd2;
      4'h2: return lk && sp == 2'd1;
      4'h3: return lk && sp == 2'd0;
      4'h4: return lk && (sp == 2'd1 || sp == 2'd2);
      4'h5: return lk && (sp == 2'd0 || sp == 2'd2);
      4'h6: return lk && sp < 2'd2;
      4'h8: return lk && fd;
      4'hc: return af;
      4'hf: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ==========
  // scenarios
  task automatic t_reset();
    #1;
    chk("pins after reset", 4'hf, status_lamp_pins);
    rd(8'h00, d);
    chk("mode reset", 32'h0000_3210, d);
    rd(8'h04, d);
    chk("behav reset", 32'h0000_0000, d);
    rd(8'h08, d);
    chk("polar reset", 32'h0000_0000, d);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, d);
    chk("unmapped", 32'h0000_0000, d);
    setin(1, 1, 1, 0, 0, 0, 0);
    settle();
    chk("lamps per pin", 4'h5, lamp_on);
    rd(8'h0c, d);
    chk("status", 32'h0000_0ba5, d);
  endtask
  task automatic t_modes();
    logic e;
    for (int m = 0; m < 16; m++) begin
      wr(8'h00, {16'h0, {4{m[3:0]}}});
      for (int k = 0; k < 16; k++) begin
        setin(k[0], k[2:1], k[3], 0, 0, 0, k[3]);
        settle();
        e = exp_on(m[3:0], k[0], k[2:1], k[3], k[3]);
        chk("lamp static", {4{e}}, lamp_on);
      end
    end
  endtask
  task automatic t_blink();
    wr(8'h00, 32'h0000_3210);
    setin(1, 2, 1, 0, 1, 0, 0);
    for (int r = 0; r < 4; r++) begin
      wr(8'h04, r << 8);
      lit((400 >> r) * MS, n);
      chk_rng("blink lit", (200 >> r) * MS, (200 >> r) * MS, n);
    end
    wr(8'h04, 32'h0000_0301);
    lit(500, n);
    chk_rng("combine off lit", 500, 500, n);
    wr(8'h00, 32'h0000_321a);
    wr(8'h04, 32'h0001_0300);
    lit(500, n);
    chk_rng("rx only lit", 0, 0, n);
    setin(1, 2, 1, 1, 0, 0, 0);
    lit(500, n);
    chk_rng("tx lit", 250, 250, n);
    wr(8'h00, 32'h0000_3218);
    wr(8'h04, 32'h0000_0300);
    setin(1, 1, 0, 0, 0, 1, 0);
    lit(500, n);
    chk_rng("half duplex coll lit", 250, 250, n);
    wr(8'h00, 32'h0000_3219);
    lit(500, n);
    chk_rng("coll lit", 250, 250, n);
  endtask
  task automatic t_stretch();
    int len;
    // mid-run reset puts every stretcher back to idle after the blink traffic
    @(posedge core_clk);
    rst_b <= 1'b0;
    collision <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk("pins in mid-run reset", 4'hf, status_lamp_pins);
    @(posedge core_clk);
    rst_b <= 1'b1;
    rd(8'h00, d);
    chk("mode after mid-run reset", 32'h0000_3210, d);
    wr(8'h00, 32'h0000_3219);
    setin(1, 2, 1, 0, 0, 0, 0);
    for (int r = 0; r < 4; r++) begin
      len = (50 << r) * MS;
      wr(8'h04, 32'h10 | (r << 8));
      pulse_coll();
      n = 0;
      while (lamp_on[0] !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      n = 0;
      while (lamp_on[0] === 1'b1 && n < 5000) begin
        tick();
        n++;
      end
      chk_rng("stretch on", len, len + MS + 2, n);
      pulse_coll();
      n = 2;
      while (lamp_on[0] !== 1'b1 && n < 5000) begin
        tick();
        n++;
      end
      chk_rng("stretch off", len, len + MS + 4, n);
      while (lamp_on[0] === 1'b1 && n < 10000) begin
        tick();
        n++;
      end
      // let the last off phase run out so the next rate starts from idle
      repeat (len + MS + 2) @(posedge core_clk);
    end
  endtask
  task automatic t_polar();
    wr(8'h00, 32'h0000_ffff);
    wr(8'h04, 32'h0002_0000);
    lit(100, n);
    chk_rng("pulsing lit", 20, 20, n);
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_000f);
    pol <= 4'hf;
    settle();
    chk("inverted on pins", 4'hf, status_lamp_pins);
    wr(8'h00, 32'h0000_eeee);
    settle();
    chk("inverted off pins", 4'h0, status_lamp_pins);
    wr(8'h08, 32'h0000_0000);
    pol <= 4'h0;
  endtask
  task automatic t_cfg();
    @(posedge core_clk);
    cfg_mode <= 16'heeef;
    cfg_behav <= 18'h2_0000;
    cfg_invert <= 4'h2;
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    rd(8'h00, d);
    chk("loaded mode", 32'h0000_eeef, d);
    rd(8'h04, d);
    chk("loaded behav", 32'h0002_0000, d);
    rd(8'h08, d);
    chk("loaded polar", 32'h0000_0002, d);
    lit(100, n);
    chk_rng("loaded pulsing lit", 20, 20, n);
    @(posedge core_clk);
    cfg_mode <= 16'h0000;
    cfg_load <= 1'b1;
    reg_addr <= 8'h00;
    reg_wdata <= 32'h0000_ffff;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    reg_wr <= 1'b0;
    rd(8'h00, d);
    chk("write beats load", 32'h0000_ffff, d);
  endtask

  // ==========
  // verdict, main sequence and watchdog
  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_modes();
    t_blink();
    t_stretch();
    t_polar();
    t_cfg();
    report_and_stop();
  end
  // about 42k cycles expected; give up at 75k
  initial begin
    #600us;
    num_errors++;
    report_and_stop();
  end
endmodule // tb_phy_status_lamp_driver
